// file: include/ct_amp_pkg.sv
// package for the center-terminal amplifier B/C configuration block
// assumes a 100 MHz clock and a plain register port with byte-wide data
package ct_amp_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int CHANNELS = 4;
	localparam logic [ADDR_W-1:0] TERMINAL_AMP_B_C_CONTROL_ADDR = 5'h19;
	localparam logic [ADDR_W-1:0] CHAN_MUX_BASE_ADDR = 5'h05;
	localparam logic [ADDR_W-1:0] AMP_A_CONTROL_ADDR = 5'h1C;
	localparam int AMP_C_ON_BIT = 7;
	localparam int AMP_B_ON_BIT = 6;
	localparam int AMP_A_ON_BIT = 3;
	localparam int AMP_B_SEL_MSB = 5;
	localparam int AMP_B_SEL_LSB = 3;
	localparam int AMP_C_SEL_MSB = 2;
	localparam int AMP_C_SEL_LSB = 0;
	localparam int MUX_MSB = 2;
	localparam logic [2:0] AMP_B_SEL_RESET = 3'h2;
	localparam logic [2:0] AMP_C_SEL_RESET = 3'h4;
	localparam logic [DATA_W-1:0] TERMINAL_AMP_B_C_CONTROL_RESET = 8'h14;
	localparam logic [DATA_W-1:0] CHAN_MUX_RESET = 8'h00;
	localparam logic [DATA_W-1:0] AMP_A_CONTROL_RESET = 8'h00;
	localparam logic [2:0] MUX_RETURN_POS = 3'h6;
	localparam logic [2:0] MUX_RETURN_NEG = 3'h7;
	localparam int CLOCK_HZ = 100000000;
	localparam int CHOP_HZ = 8000;
	localparam int CHOP_HALF_CYCLES = CLOCK_HZ / (2 * CHOP_HZ);
	localparam int CHOP_CNT_W = 13;
	localparam logic [CHOP_CNT_W-1:0] CHOP_CNT_LAST = 13'(CHOP_HALF_CYCLES - 1);
endpackage

// file: rtl/center_terminal_amp_config.sv
// configuration registers for averaging-terminal amplifiers B and C,
// channel return-path multiplexing and the input chopping clock
// assumes a one-cycle strobed register port from logic on the same clock
`timescale 1ns/1ps
module center_terminal_amp_config
	import ct_amp_pkg::*;
#(
	parameter int NUM_CHANNELS = CHANNELS
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	output logic amp_a_power_on,
	output logic amp_b_power_on,
	output logic amp_c_power_on,
	output logic [2:0] amp_b_input_select,
	output logic [2:0] amp_c_input_select,
	output logic [2*CHANNELS-1:0] amp_b_switches,
	output logic [2*CHANNELS-1:0] amp_c_switches,
	output logic [NUM_CHANNELS-1:0] return_to_pos,
	output logic [NUM_CHANNELS-1:0] return_to_neg,
	output logic chop_clock
);
	// ==================================================
	// register storage
	logic [DATA_W-1:0] terminal_amp_b_c_control;
	logic [DATA_W-1:0] amp_a_control;
	logic [DATA_W-1:0] chan_mux [NUM_CHANNELS];

	wire hit_bc;
	wire hit_a;
	wire [NUM_CHANNELS-1:0] hit_mux;
	assign hit_bc = (reg_addr == TERMINAL_AMP_B_C_CONTROL_ADDR);
	assign hit_a = (reg_addr == AMP_A_CONTROL_ADDR);

	always_ff @(posedge clock) begin
		if (rst) begin
			terminal_amp_b_c_control <= TERMINAL_AMP_B_C_CONTROL_RESET;
			amp_a_control <= AMP_A_CONTROL_RESET;
		end else if (clock_enable && reg_write) begin
			if (hit_bc)
				terminal_amp_b_c_control <= reg_wdata;
			if (hit_a)
				amp_a_control <= reg_wdata;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CHANNELS; g++) begin : gen_mux
			assign hit_mux[g] = (reg_addr == CHAN_MUX_BASE_ADDR + ADDR_W'(g));
			always_ff @(posedge clock) begin
				if (rst)
					chan_mux[g] <= CHAN_MUX_RESET;
				else if (clock_enable && reg_write && hit_mux[g])
					chan_mux[g] <= reg_wdata;
			end
			always_ff @(posedge clock) begin
				if (rst) begin
					return_to_pos[g] <= 1'b0;
					return_to_neg[g] <= 1'b0;
				end else if (clock_enable) begin
					return_to_pos[g] <= (chan_mux[g][MUX_MSB:0] == MUX_RETURN_POS);
					return_to_neg[g] <= (chan_mux[g][MUX_MSB:0] == MUX_RETURN_NEG);
				end
			end
		end
	endgenerate

	// ==================================================
	// read path
	logic [DATA_W-1:0] mux_rd;
	always_comb begin
		mux_rd = '0;
		for (int i = 0; i < NUM_CHANNELS; i++)
			if (hit_mux[i])
				mux_rd = chan_mux[i];
	end

	wire [DATA_W-1:0] next_rdata;
	assign next_rdata = !reg_read ? '0 :
		hit_bc ? terminal_amp_b_c_control :
		hit_a ? amp_a_control : mux_rd;

	always_ff @(posedge clock) begin
		if (rst)
			reg_rdata <= '0;
		else if (clock_enable)
			reg_rdata <= next_rdata;
	end

	// ==================================================
	// control outputs
	wire next_b_on;
	wire next_c_on;
	wire next_a_on;
	assign next_c_on = terminal_amp_b_c_control[AMP_C_ON_BIT];
	assign next_b_on = terminal_amp_b_c_control[AMP_B_ON_BIT];
	assign next_a_on = amp_a_control[AMP_A_ON_BIT];

	always_ff @(posedge clock) begin
		if (rst) begin
			amp_a_power_on <= 1'b0;
			amp_b_power_on <= 1'b0;
			amp_c_power_on <= 1'b0;
			amp_b_input_select <= AMP_B_SEL_RESET;
			amp_c_input_select <= AMP_C_SEL_RESET;
		end else if (clock_enable) begin
			amp_a_power_on <= next_a_on;
			amp_b_power_on <= next_b_on;
			amp_c_power_on <= next_c_on;
			amp_b_input_select <= terminal_amp_b_c_control[AMP_B_SEL_MSB:AMP_B_SEL_LSB];
			amp_c_input_select <= terminal_amp_b_c_control[AMP_C_SEL_MSB:AMP_C_SEL_LSB];
		end
	end

	ct_input_decode u_dec_b (
		.clock(clock),
		.rst(rst),
		.enable(clock_enable),
		.power_on(next_b_on),
		.select(terminal_amp_b_c_control[AMP_B_SEL_MSB:AMP_B_SEL_LSB]),
		.switches(amp_b_switches)
	);

	ct_input_decode u_dec_c (
		.clock(clock),
		.rst(rst),
		.enable(clock_enable),
		.power_on(next_c_on),
		.select(terminal_amp_b_c_control[AMP_C_SEL_MSB:AMP_C_SEL_LSB]),
		.switches(amp_c_switches)
	);

	// ==================================================
	// 8 kHz chopper, held low while all amplifiers are off
	logic [CHOP_CNT_W-1:0] chop_cnt;
	wire any_on;
	assign any_on = next_a_on | next_b_on | next_c_on;

	always_ff @(posedge clock) begin
		if (rst) begin
			chop_cnt <= '0;
			chop_clock <= 1'b0;
		end else if (clock_enable) begin
			if (!any_on) begin
				chop_cnt <= '0;
				chop_clock <= 1'b0;
			end else if (chop_cnt == CHOP_CNT_LAST) begin
				chop_cnt <= '0;
				chop_clock <= ~chop_clock;
			end else begin
				chop_cnt <= chop_cnt + 1'b1;
			end
		end
	end

	// ==================================================
	// checks
	chk_write_to_read: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_bc ##1 clock_enable && reg_read && hit_bc
		##1 clock_enable |-> reg_rdata == $past(reg_wdata, 2))
		else $error("register readback differs from write");
	chk_power_follow: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_bc ##1 clock_enable ##1 clock_enable
		|-> amp_c_power_on == $past(reg_wdata[AMP_C_ON_BIT], 2)
		&& amp_b_power_on == $past(reg_wdata[AMP_B_ON_BIT], 2))
		else $error("power bits not applied");
	chk_b_select: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_bc ##1 clock_enable ##1 clock_enable
		|-> amp_b_input_select == $past(reg_wdata[5:3], 2))
		else $error("amplifier b selector wrong");
	chk_c_select: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_bc ##1 clock_enable ##1 clock_enable
		|-> amp_c_input_select == $past(reg_wdata[2:0], 2))
		else $error("amplifier c selector wrong");
	chk_b_onehot: assert property (@(posedge clock) disable iff (rst)
		amp_b_power_on |-> amp_b_switches == (8'h01 << amp_b_input_select))
		else $error("amplifier b switch decode wrong");
	chk_c_off: assert property (@(posedge clock) disable iff (rst)
		!amp_c_power_on |-> amp_c_switches == 8'h00)
		else $error("amplifier c switched while off");
	chk_return_excl: assert property (@(posedge clock) disable iff (rst)
		(return_to_pos & return_to_neg) == '0)
		else $error("return routed to both sides");
	chk_chop_idle: assert property (@(posedge clock) disable iff (rst)
		clock_enable && !any_on ##1 clock_enable |-> !chop_clock && chop_cnt == '0)
		else $error("chopper running while amplifiers off");
	chk_read_reset: assert property (@(posedge clock)
		rst ##1 !rst ##1 !rst ##1 !rst && clock_enable && reg_read && hit_bc ##1 !rst
		|-> reg_rdata == TERMINAL_AMP_B_C_CONTROL_RESET)
		else $error("reset value of register wrong");

	// ==================================================
	// register port and output tracking checks
	chk_c_onehot: assert property (@(posedge clock) disable iff (rst)
		amp_c_power_on |-> amp_c_switches == (8'h01 << amp_c_input_select))
		else $error("amplifier c switch decode wrong");

	chk_b_off: assert property (@(posedge clock) disable iff (rst)
		!amp_b_power_on |-> amp_b_switches == 8'h00)
		else $error("amplifier b switched while off");

	chk_rdata_idle: assert property (@(posedge clock) disable iff (rst)
		clock_enable && !reg_read |=> reg_rdata == '0)
		else $error("read data not cleared");

	chk_read_bc: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_read && hit_bc |=> reg_rdata == $past(terminal_amp_b_c_control))
		else $error("b c register read wrong");

	chk_read_a: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_read && hit_a |=> reg_rdata == $past(amp_a_control))
		else $error("amplifier a register read wrong");

	chk_read_mux0: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_read && hit_mux[0] |=> reg_rdata == $past(chan_mux[0]))
		else $error("channel mux read wrong");

	chk_read_unmapped: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_read && !hit_bc && !hit_a && hit_mux == '0 |=> reg_rdata == '0)
		else $error("unmapped read not zero");

	chk_write_reg: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_bc |=> terminal_amp_b_c_control == $past(reg_wdata))
		else $error("b c register write lost");

	chk_no_write: assert property (@(posedge clock) disable iff (rst)
		!(clock_enable && reg_write && hit_bc) |=> $stable(terminal_amp_b_c_control))
		else $error("b c register changed without write");

	chk_a_write: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_a |=> amp_a_control == $past(reg_wdata))
		else $error("amplifier a register write lost");

	chk_mux0_write: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_mux[0] |=> chan_mux[0] == $past(reg_wdata))
		else $error("channel 1 mux write lost");

	chk_mux3_write: assert property (@(posedge clock) disable iff (rst)
		clock_enable && reg_write && hit_mux[3] |=> chan_mux[3] == $past(reg_wdata))
		else $error("channel 4 mux write lost");

	chk_freeze_out: assert property (@(posedge clock) disable iff (rst)
		!clock_enable |=> $stable(amp_b_power_on) && $stable(amp_c_power_on)
		&& $stable(chop_clock) && $stable(reg_rdata))
		else $error("outputs moved while frozen");

	chk_a_power: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> amp_a_power_on == $past(amp_a_control[AMP_A_ON_BIT]))
		else $error("amplifier a power not applied");

	chk_b_power_reg: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> amp_b_power_on == $past(terminal_amp_b_c_control[AMP_B_ON_BIT]))
		else $error("amplifier b power not tracking");

	chk_c_power_reg: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> amp_c_power_on == $past(terminal_amp_b_c_control[AMP_C_ON_BIT]))
		else $error("amplifier c power not tracking");

	chk_b_sel_reg: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> amp_b_input_select == $past(terminal_amp_b_c_control[5:3]))
		else $error("amplifier b selector not tracking");

	chk_c_sel_reg: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> amp_c_input_select == $past(terminal_amp_b_c_control[2:0]))
		else $error("amplifier c selector not tracking");

	chk_return_pos0: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> return_to_pos[0] == ($past(chan_mux[0][2:0]) == 3'h6))
		else $error("channel 1 positive return wrong");

	chk_return_neg0: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> return_to_neg[0] == ($past(chan_mux[0][2:0]) == 3'h7))
		else $error("channel 1 negative return wrong");

	chk_return_pos3: assert property (@(posedge clock) disable iff (rst)
		clock_enable |=> return_to_pos[3] == ($past(chan_mux[3][2:0]) == 3'h6))
		else $error("channel 4 positive return wrong");

	chk_chop_range: assert property (@(posedge clock) disable iff (rst)
		chop_cnt <= CHOP_CNT_LAST)
		else $error("chopper counter out of range");

	chk_chop_toggle: assert property (@(posedge clock) disable iff (rst)
		clock_enable && any_on && chop_cnt == CHOP_CNT_LAST |=> chop_clock != $past(chop_clock))
		else $error("chopper missed its toggle");

	chk_chop_hold: assert property (@(posedge clock) disable iff (rst)
		clock_enable && any_on && chop_cnt != CHOP_CNT_LAST |=> $stable(chop_clock))
		else $error("chopper toggled early");
endmodule

// file: rtl/ct_input_decode.sv
// one-hot decoder of a 3-bit electrode selector onto eight switch controls
// assumes synchronous logic on the common clock
`timescale 1ns/1ps
module ct_input_decode
	import ct_amp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic enable,
	input wire logic power_on,
	input wire logic [2:0] select,
	output logic [2*CHANNELS-1:0] switches
);
	wire [2*CHANNELS-1:0] next_switches;
	// bit 2k: channel k+1 positive side, bit 2k+1: negative side
	assign next_switches = power_on ? (8'h01 << select) : 8'h00;

	always_ff @(posedge clock) begin
		if (rst)
			switches <= '0;
		else if (enable)
			switches <= next_switches;
	end
endmodule

// file: test/tb.sv
// self-checking bench for the amplifier B/C configuration block
// assumes a 100 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
module tb;
	import ct_amp_pkg::*;
	logic clock = 0, rst = 1, clock_enable = 1, reg_write = 0, reg_read = 0;
	logic [ADDR_W-1:0] reg_addr = 5'h00;
	logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
	logic amp_a_power_on, amp_b_power_on, amp_c_power_on, chop_clock;
	logic [2:0] amp_b_input_select, amp_c_input_select;
	logic [2*CHANNELS-1:0] amp_b_switches, amp_c_switches;
	logic [CHANNELS-1:0] return_to_pos, return_to_neg;
	int err_total = 0, total_checks = 0;
	center_terminal_amp_config uut (.clock(clock), .rst(rst), .clock_enable(clock_enable),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .amp_a_power_on(amp_a_power_on), .amp_b_power_on(amp_b_power_on),
		.amp_c_power_on(amp_c_power_on), .amp_b_input_select(amp_b_input_select),
		.amp_c_input_select(amp_c_input_select), .amp_b_switches(amp_b_switches),
		.amp_c_switches(amp_c_switches), .return_to_pos(return_to_pos),
		.return_to_neg(return_to_neg), .chop_clock(chop_clock));
	initial begin
		forever #5 clock = ~clock;
	end
	// ==============================
	// bus and compare helpers
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk("read data", {8'h00, reg_rdata}, {8'h00, exp});
	endtask
	// ==============================
	// scenarios
	task automatic t_reset;
		chk("power bc", {amp_b_power_on, amp_c_power_on}, 16'h0000);
		chk("b select", amp_b_input_select, 16'h0002);
		chk("c select", amp_c_input_select, 16'h0004);
		chk("chop idle", chop_clock, 16'h0000);
		rd_chk(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'h14);
	endtask
	task automatic t_codes;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(TERMINAL_AMP_B_C_CONTROL_ADDR, {2'b11, c, ~c});
			chk("b select", amp_b_input_select, {13'h0000, c});
			chk("c select", amp_c_input_select, {13'h0000, ~c});
			chk("b switches", amp_b_switches, 16'h0001 << c);
			chk("c switches", amp_c_switches, 16'h0001 << (~c));
			rd_chk(TERMINAL_AMP_B_C_CONTROL_ADDR, {2'b11, c, ~c});
		end
	endtask
	task automatic t_power;
		wr(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'h94);
		chk("power bc", {amp_b_power_on, amp_c_power_on}, 16'h0001);
		chk("b off switches", amp_b_switches, 16'h0000);
		chk("c on switches", amp_c_switches, 16'h0010);
		wr(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'h54);
		chk("power bc", {amp_b_power_on, amp_c_power_on}, 16'h0002);
		wr(AMP_A_CONTROL_ADDR, 8'h08);
		chk("power a", amp_a_power_on, 16'h0001);
		rd_chk(5'h1F, 8'h00);
		clock_enable <= 1'b0;
		wr(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'hFF);
		clock_enable <= 1'b1;
		rd_chk(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'h54);
	endtask
	task automatic t_return;
		for (int k = 0; k < CHANNELS; k++) begin
			wr(CHAN_MUX_BASE_ADDR + 5'(k), {5'h00, MUX_RETURN_POS});
			chk("return pos", {return_to_pos, return_to_neg}, 16'h0010 << k);
			wr(CHAN_MUX_BASE_ADDR + 5'(k), {5'h00, MUX_RETURN_NEG});
			chk("return neg", {return_to_pos, return_to_neg}, 16'h0001 << k);
			wr(CHAN_MUX_BASE_ADDR + 5'(k), 8'h05);
		end
		chk("return idle", {return_to_pos, return_to_neg}, 16'h0000);
	endtask
	task automatic t_back_to_back;
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= TERMINAL_AMP_B_C_CONTROL_ADDR;
		reg_wdata <= 8'hC1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk("read after write", {8'h00, reg_rdata}, 16'h00C1);
		chk("power bc", {amp_b_power_on, amp_c_power_on}, 16'h0003);
		chk("c select", amp_c_input_select, 16'h0001);
	endtask
	task automatic t_chop;
		int n;
		logic prev;
		for (int e = 0; e < 3; e++) begin
			prev = chop_clock;
			n = 0;
			while (chop_clock === prev && n < 20000) begin
				@(posedge clock);
				#1;
				n++;
			end
			if (e > 0) chk("chop half period", 16'(n), 16'(CHOP_HALF_CYCLES));
		end
		wr(TERMINAL_AMP_B_C_CONTROL_ADDR, 8'h14);
		wr(AMP_A_CONTROL_ADDR, 8'h00);
		repeat (2) @(posedge clock);
		#1;
		chk("chop stops", chop_clock, 16'h0000);
	endtask
	// ==============================
	// closing and main sequence
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		t_reset();
		t_codes();
		t_power();
		t_return();
		t_back_to_back();
		t_chop();
		tally_and_finish();
	end
endmodule
